// file: perfmon_pkg.sv
// constants shared by the receive-path performance monitor files
package perfmon_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned ONE_SECOND_NS = 1_000_000_000;
	localparam int unsigned TICK_CYCLES   = ONE_SECOND_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int unsigned APB_ADDR_W = 12;
	localparam int unsigned APB_DATA_W = 32;
	localparam int unsigned REG_IDX_W  = 8;

	// ------------------------------------------------------------
	// direct register indices (byte address is four times)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_INDIRECT_SELECT = 8'h0E;
	localparam logic [7:0] REG_INDIRECT_DATA   = 8'h0F;
	localparam logic [7:0] REG_UPDATE_CTRL     = 8'hC2;
	localparam logic [7:0] REG_OVF_ENABLE_0    = 8'hC3;
	localparam logic [7:0] REG_OVF_ENABLE_1    = 8'hC4;
	localparam logic [7:0] REG_OVF_FLAGS_0     = 8'hC5;
	localparam logic [7:0] REG_OVF_FLAGS_1     = 8'hC6;

	// ------------------------------------------------------------
	// update control fields
	// ------------------------------------------------------------
	localparam int unsigned CTRL_MANUAL_BIT = 0;
	localparam int unsigned CTRL_AUTO_BIT   = 1;

	// ------------------------------------------------------------
	// overflow bit positions in flags_0 / enable_0, and OVF_LINE in flags_1 / enable_1
	// ------------------------------------------------------------
	localparam int unsigned OVF_FRAME      = 0;
	localparam int unsigned OVF_CRC4       = 1;
	localparam int unsigned OVF_FAR_BLOCK  = 2;
	localparam int unsigned OVF_ALIGN      = 3;
	localparam int unsigned OVF_SYNC_LOSS  = 4;
	localparam int unsigned OVF_PATTERN    = 5;
	localparam int unsigned OVF_TERM_FAR   = 6;
	localparam int unsigned OVF_TERM_CRC   = 7;
	localparam int unsigned OVF_LINE       = 0;

	// ------------------------------------------------------------
	// counter widths
	// ------------------------------------------------------------
	localparam int unsigned LINE_W      = 16;
	localparam int unsigned FRAME_W     = 12;
	localparam int unsigned CRC4_W      = 10;
	localparam int unsigned FAR_BLOCK_W = 10;
	localparam int unsigned ALIGN_W     = 3;
	localparam int unsigned SYNC_LOSS_W = 5;
	localparam int unsigned PATTERN_W   = 16;
	localparam int unsigned TERM_FAR_W  = 10;
	localparam int unsigned TERM_CRC_W  = 10;

	// ------------------------------------------------------------
	// indirect register indices
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_CRC4_LO      = 4'h0;
	localparam logic [3:0] IDX_CRC4_HI      = 4'h1;
	localparam logic [3:0] IDX_FRAME_LO     = 4'h2;
	localparam logic [3:0] IDX_FRAME_HI     = 4'h3;
	localparam logic [3:0] IDX_ALIGN        = 4'h4;
	localparam logic [3:0] IDX_SYNC_LOSS    = 4'h5;
	localparam logic [3:0] IDX_PATTERN_LO   = 4'h6;
	localparam logic [3:0] IDX_PATTERN_HI   = 4'h7;
	localparam logic [3:0] IDX_LINE_LO      = 4'h8;
	localparam logic [3:0] IDX_LINE_HI      = 4'h9;
	localparam logic [3:0] IDX_TERM_CRC_LO  = 4'hA;
	localparam logic [3:0] IDX_TERM_CRC_HI  = 4'hB;
	localparam logic [3:0] IDX_FAR_BLOCK_LO = 4'hC;
	localparam logic [3:0] IDX_FAR_BLOCK_HI = 4'hD;
	localparam logic [3:0] IDX_TERM_FAR_LO  = 4'hE;
	localparam logic [3:0] IDX_TERM_FAR_HI  = 4'hF;

endpackage

// file: perf_event_counter.sv
// saturating event counter with snapshot register and overflow pulse
module perf_event_counter #(
	parameter int unsigned WIDTH = 16
) (
	// clock and control
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// event and update
	input  wire logic             event_in,
	input  wire logic             snap_in,
	// results
	output logic [WIDTH-1:0]      snap_value,
	output logic                  overflow
);

	typedef struct packed {
		logic [WIDTH-1:0] live;
		logic [WIDTH-1:0] held;
		logic             ovf;
	} cnt_state_t;

	cnt_state_t s_r;
	cnt_state_t s_nxt;

	always_comb begin
		s_nxt     = s_r;
		s_nxt.ovf = 1'b0;
		if (snap_in) begin
			s_nxt.held = s_r.live;                                         // R02 R03
			// event in the update cycle opens the new period
			s_nxt.live = {{(WIDTH-1){1'b0}}, event_in};                    // R04 R05
		end else if (event_in) begin
			if (s_r.live == {WIDTH{1'b1}}) begin
				s_nxt.ovf = 1'b1;                                          // R01 R19
			end else begin
				s_nxt.live = s_r.live + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign snap_value = s_r.held;
	assign overflow   = s_r.ovf;

endmodule

// file: second_tick_gen.sv
// prescaler that pulses once per counting period while enabled
module second_tick_gen #(
	parameter int unsigned PERIOD = 100_000_000
) (
	// clock and control
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic enable,
	// one-cycle tick
	output logic      tick
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} tick_state_t;

	tick_state_t s_r;
	tick_state_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = 1'b0;
		// held at zero while disabled, so the first tick is a full period away
		if (!enable) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt == 32'(PERIOD - 1)) begin
			s_nxt.cnt  = '0;
			s_nxt.tick = 1'b1;                                             // R20
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule

// file: e1_performance_monitor.sv
// receive-path performance monitor: counters, snapshots, overflow flags, APB slave
//
// Overview of operation
// R01: counter overflow sets its flag; enabled flag raises the interrupt request.
// R02: with automatic update on, all counters copy to snapshots each second.
// R03: manual trigger rising edge copies all counters, regardless of automatic bit.
// R04: every update clears the live counters and starts a fresh period.
// R05: an event during an update cycle counts in the new period.
// R06: software writes a four-bit index selecting the presented indirect byte.
// R07: access data register shows the selected indirect byte.
// R08: 16-bit line count: bipolar violations in AMI, code violations in HDB3.
// R09: 12-bit frame alignment error count at indices 03 and 02.
// R10: 10-bit CRC-4 error count at indices 01 and 00.
// R11: 10-bit far end block error count at indices 0D and 0C.
// R12: 3-bit alignment position change count at index 04.
// R13: 5-bit loss of frame synchronization count at index 05.
// R14: 16-bit pattern detector bit error count at indices 07 and 06.
// R15: 10-bit terminal far end block error count at indices 0F and 0E.
// R16: 10-bit terminal CRC error count at indices 0B and 0A.
// R17: line flag and enable at C6 and C4; others at C5 and C3.
// R18: flags clear by writing one; interrupt stays while enabled flag set.
// R19: live counters saturate at full scale until the next update.
// R20: one-second tick comes from a prescaler on the system clock.
//
// Added by the designer: the APB register port.
module e1_performance_monitor
	#(
	parameter int unsigned TICK_CYCLES = perfmon_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input  wire logic                                CLK_SYS,
	input  wire logic                                RST,
	input  wire logic                                CE,
	// APB slave
	input  wire logic                                PSEL,
	input  wire logic                                PENABLE,
	input  wire logic                                PWRITE,
	input  wire logic [perfmon_pkg::APB_ADDR_W-1:0]  PADDR,
	input  wire logic [perfmon_pkg::APB_DATA_W-1:0]  PWDATA,
	input  wire logic [3:0]                          PSTRB,
	output logic      [perfmon_pkg::APB_DATA_W-1:0]  PRDATA,
	output logic                                     PREADY,
	output logic                                     PSLVERR,
	// line decoder events
	input  wire logic                                HDB3_MODE,
	input  wire logic                                BIPOLAR_VIOLATION,
	input  wire logic                                CODE_VIOLATION,
	// framer and pattern detector events
	input  wire logic                                FRAME_ERROR,
	input  wire logic                                CRC4_ERROR,
	input  wire logic                                FAR_BLOCK_ERROR,
	input  wire logic                                ALIGNMENT_CHANGE,
	input  wire logic                                SYNC_LOSS,
	input  wire logic                                PATTERN_ERROR,
	input  wire logic                                TERMINAL_FAR_BLOCK_ERROR,
	input  wire logic                                TERMINAL_CRC_ERROR,
	// interrupt request
	output logic                                     IRQ
);

	import perfmon_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [APB_DATA_W-1:0] prdata;
		logic                  pready;
		logic                  pslverr;
		logic [3:0]            select;
		logic                  manual;
		logic                  manual_prev;
		logic                  auto_en;
		logic [7:0]            enable_0;
		logic                  enable_1;
		logic [7:0]            flags_0;
		logic                  flags_1;
		logic                  irq;
	} mon_state_t;

	mon_state_t s_r;
	mon_state_t s_nxt;

	// ------------------------------------------------------------
	// update pulse
	// ------------------------------------------------------------
	logic tick;
	logic snap;

	second_tick_gen #(
		.PERIOD (TICK_CYCLES)
	) u_tick (
		.clk    (CLK_SYS),
		.rst    (RST),
		.ce     (CE),
		.enable (s_r.auto_en),
		.tick   (tick)
	);

	// manual edge works whatever the automatic bit holds
	assign snap = (tick & s_r.auto_en) | (s_r.manual & ~s_r.manual_prev);  // R02 R03

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	logic                   line_event;
	logic [LINE_W-1:0]      line_snap;
	logic [FRAME_W-1:0]     frame_snap;
	logic [CRC4_W-1:0]      crc4_snap;
	logic [FAR_BLOCK_W-1:0] far_block_snap;
	logic [ALIGN_W-1:0]     align_snap;
	logic [SYNC_LOSS_W-1:0] sync_loss_snap;
	logic [PATTERN_W-1:0]   pattern_snap;
	logic [TERM_FAR_W-1:0]  term_far_snap;
	logic [TERM_CRC_W-1:0]  term_crc_snap;
	logic [7:0]             ovf_0;
	logic                   ovf_line;

	assign line_event = HDB3_MODE ? CODE_VIOLATION : BIPOLAR_VIOLATION;  // R08

	// every counter takes the same update pulse, so one snapshot bank
	// always describes a single counting period
	perf_event_counter #(
		.WIDTH (LINE_W)
	) u_line (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (line_event),
		.snap_in    (snap),
		.snap_value (line_snap),
		.overflow   (ovf_line)
	);

	perf_event_counter #(
		.WIDTH (FRAME_W)
	) u_frame (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (FRAME_ERROR),                                         // R09
		.snap_in    (snap),
		.snap_value (frame_snap),
		.overflow   (ovf_0[OVF_FRAME])
	);

	perf_event_counter #(
		.WIDTH (CRC4_W)
	) u_crc4 (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (CRC4_ERROR),                                          // R10
		.snap_in    (snap),
		.snap_value (crc4_snap),
		.overflow   (ovf_0[OVF_CRC4])
	);

	perf_event_counter #(
		.WIDTH (FAR_BLOCK_W)
	) u_far_block (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (FAR_BLOCK_ERROR),                                     // R11
		.snap_in    (snap),
		.snap_value (far_block_snap),
		.overflow   (ovf_0[OVF_FAR_BLOCK])
	);

	perf_event_counter #(
		.WIDTH (ALIGN_W)
	) u_align (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (ALIGNMENT_CHANGE),                                    // R12
		.snap_in    (snap),
		.snap_value (align_snap),
		.overflow   (ovf_0[OVF_ALIGN])
	);

	perf_event_counter #(
		.WIDTH (SYNC_LOSS_W)
	) u_sync_loss (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (SYNC_LOSS),                                           // R13
		.snap_in    (snap),
		.snap_value (sync_loss_snap),
		.overflow   (ovf_0[OVF_SYNC_LOSS])
	);

	perf_event_counter #(
		.WIDTH (PATTERN_W)
	) u_pattern (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (PATTERN_ERROR),                                       // R14
		.snap_in    (snap),
		.snap_value (pattern_snap),
		.overflow   (ovf_0[OVF_PATTERN])
	);

	perf_event_counter #(
		.WIDTH (TERM_FAR_W)
	) u_term_far (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (TERMINAL_FAR_BLOCK_ERROR),                            // R15
		.snap_in    (snap),
		.snap_value (term_far_snap),
		.overflow   (ovf_0[OVF_TERM_FAR])
	);

	perf_event_counter #(
		.WIDTH (TERM_CRC_W)
	) u_term_crc (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.event_in   (TERMINAL_CRC_ERROR),                                  // R16
		.snap_in    (snap),
		.snap_value (term_crc_snap),
		.overflow   (ovf_0[OVF_TERM_CRC])
	);

	// ------------------------------------------------------------
	// indirect byte selection
	// ------------------------------------------------------------
	logic [7:0] indirect_read_value;

	always_comb begin
		unique case (s_r.select)                                           // R06 R07
			IDX_CRC4_LO:      indirect_read_value = crc4_snap[7:0];
			IDX_CRC4_HI:      indirect_read_value = {6'h00, crc4_snap[9:8]};
			IDX_FRAME_LO:     indirect_read_value = frame_snap[7:0];
			IDX_FRAME_HI:     indirect_read_value = {4'h0, frame_snap[11:8]};
			IDX_ALIGN:        indirect_read_value = {5'h00, align_snap};
			IDX_SYNC_LOSS:    indirect_read_value = {3'h0, sync_loss_snap};
			IDX_PATTERN_LO:   indirect_read_value = pattern_snap[7:0];
			IDX_PATTERN_HI:   indirect_read_value = pattern_snap[15:8];
			IDX_LINE_LO:      indirect_read_value = line_snap[7:0];
			IDX_LINE_HI:      indirect_read_value = line_snap[15:8];
			IDX_TERM_CRC_LO:  indirect_read_value = term_crc_snap[7:0];
			IDX_TERM_CRC_HI:  indirect_read_value = {6'h00, term_crc_snap[9:8]};
			IDX_FAR_BLOCK_LO: indirect_read_value = far_block_snap[7:0];
			IDX_FAR_BLOCK_HI: indirect_read_value = {6'h00, far_block_snap[9:8]};
			IDX_TERM_FAR_LO:  indirect_read_value = term_far_snap[7:0];
			IDX_TERM_FAR_HI:  indirect_read_value = {6'h00, term_far_snap[9:8]};
		endcase
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [REG_IDX_W-1:0] reg_idx;
	logic                 addr_ok;
	logic                 mapped;
	logic [7:0]           read_byte;
	logic                 do_write;
	logic [7:0]           wbyte;

	assign reg_idx  = PADDR[REG_IDX_W+1:2];
	assign addr_ok  = (PADDR[1:0] == 2'h0) && (PADDR[APB_ADDR_W-1:REG_IDX_W+2] == '0);
	// the register is written at the edge that also sees PREADY high
	assign do_write = PSEL & PENABLE & s_r.pready & PWRITE & addr_ok & PSTRB[0];
	assign wbyte    = PWDATA[7:0];

	always_comb begin
		mapped    = addr_ok;
		read_byte = 8'h00;
		unique case (reg_idx)
			REG_INDIRECT_SELECT: read_byte = {4'h0, s_r.select};
			REG_INDIRECT_DATA:   read_byte = indirect_read_value;         // R07
			REG_UPDATE_CTRL: begin
				read_byte[CTRL_MANUAL_BIT] = s_r.manual;
				read_byte[CTRL_AUTO_BIT]   = s_r.auto_en;
			end
			REG_OVF_ENABLE_0:    read_byte = s_r.enable_0;                // R17
			REG_OVF_ENABLE_1:    read_byte = {7'h00, s_r.enable_1};       // R17
			REG_OVF_FLAGS_0:     read_byte = s_r.flags_0;                 // R17
			REG_OVF_FLAGS_1:     read_byte = {7'h00, s_r.flags_1};        // R17
			default:             mapped    = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt             = s_r;
		s_nxt.manual_prev = s_r.manual;

		// one wait state: data captured in the first access cycle
		if (s_r.pready) begin
			s_nxt.pready  = 1'b0;
			s_nxt.pslverr = 1'b0;
		end else if (PSEL && PENABLE) begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = ~mapped;
			s_nxt.prdata  = (mapped && !PWRITE) ? {24'h000000, read_byte} : '0;
		end

		if (do_write) begin
			unique case (reg_idx)
				REG_INDIRECT_SELECT: s_nxt.select = wbyte[3:0];           // R06
				REG_UPDATE_CTRL: begin
					s_nxt.manual  = wbyte[CTRL_MANUAL_BIT];               // R03
					s_nxt.auto_en = wbyte[CTRL_AUTO_BIT];                 // R02
				end
				REG_OVF_ENABLE_0:    s_nxt.enable_0 = wbyte;
				REG_OVF_ENABLE_1:    s_nxt.enable_1 = wbyte[OVF_LINE];
				REG_OVF_FLAGS_0:     s_nxt.flags_0  = s_r.flags_0 & ~wbyte;            // R18
				REG_OVF_FLAGS_1:     s_nxt.flags_1  = s_r.flags_1 & ~wbyte[OVF_LINE];  // R18
				default: begin
				end
			endcase
		end

		// a new overflow beats a clear in the same cycle
		s_nxt.flags_0 = s_nxt.flags_0 | ovf_0;                             // R01
		s_nxt.flags_1 = s_nxt.flags_1 | ovf_line;                          // R01

		// level request, held while any enabled flag stays set
		s_nxt.irq = |(s_nxt.flags_0 & s_nxt.enable_0) |
			(s_nxt.flags_1 & s_nxt.enable_1);                              // R01 R18
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			s_r <= '0;
		end else if (CE) begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign PRDATA  = s_r.prdata;
	assign PREADY  = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign IRQ     = s_r.irq;

endmodule

// file: perfmon_props.sv
// port-level concurrent checks for the receive-path performance monitor
module perfmon_props (
	// clock and reset
	input wire logic                                CLK_SYS,
	input wire logic                                RST,
	input wire logic                                CE,
	// register bus
	input wire logic                                PSEL,
	input wire logic                                PENABLE,
	input wire logic                                PWRITE,
	input wire logic [perfmon_pkg::APB_ADDR_W-1:0]  PADDR,
	input wire logic [perfmon_pkg::APB_DATA_W-1:0]  PRDATA,
	input wire logic                                PREADY,
	input wire logic                                PSLVERR,
	// interrupt
	input wire logic                                IRQ
);
	import perfmon_pkg::*;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	sequence access_wait;
		PSEL && PENABLE && !PREADY && CE;
	endsequence
	sequence single_pulse;
		PREADY ##1 !PREADY;
	endsequence

	// a frozen clock enable would stretch the answer, so require it high
	ready_answer_a: assert property (access_wait ##1 CE |-> single_pulse)
		else $error("ready not a single pulse after one wait state");
	ready_cause_a: assert property ($rose(PREADY) |-> $past(PSEL && PENABLE))
		else $error("ready without an access phase");
	idle_no_ready_a: assert property (!PSEL && CE |=> !PREADY)
		else $error("ready while bus idle");
	write_rdata_a: assert property (PREADY && PWRITE |-> PRDATA == '0)
		else $error("read data not zero on a write");
	byte_rdata_a: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	select_ok_a: assert property (PREADY && PADDR == 12'h038 |-> !PSLVERR && PRDATA[7:4] == 4'h0)
		else $error("access port index not four bits wide");

	// ------------------------------------------------------------
	// refusals and interrupt
	// ------------------------------------------------------------
	misalign_err_a: assert property (PREADY && PADDR[1:0] != 2'b00 |-> PSLVERR)
		else $error("misaligned access not refused");
	unmapped_err_a: assert property (PREADY && PADDR[11:10] != 2'b00 |-> PSLVERR && PRDATA == '0)
		else $error("out-of-range access not refused");
	irq_hold_a: assert property (IRQ && CE && !(PREADY && PWRITE) |=> IRQ)
		else $error("interrupt dropped without a register write");
endmodule

// file: tb.sv
// self-checking bench for the receive-path performance monitor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import perfmon_pkg::*;

	localparam int TICKS = 20;
	logic        CLK_SYS = 1'b0;
	logic        RST = 1'b1;
	logic        CE = 1'b1;
	logic        PSEL = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h00000000;
	logic [3:0]  PSTRB = 4'hF;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        IRQ;
	logic        HDB3_MODE = 1'b0;
	logic        bv = 1'b0;
	logic        cv = 1'b0;
	logic [8:0]  ev = 9'h000;
	logic [8:0]  ovf;
	logic [8:0]  en;
	logic [31:0] rd;
	logic        er;
	logic        snap_req = 1'b0;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cnt[9];
	int          snap[9];
	int          wid[9] = '{FRAME_W, CRC4_W, FAR_BLOCK_W, ALIGN_W, SYNC_LOSS_W,
		PATTERN_W, TERM_FAR_W, TERM_CRC_W, LINE_W};

	always #5 CLK_SYS = ~CLK_SYS;

	e1_performance_monitor #(.TICK_CYCLES(TICKS)) dut_u (
		.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .HDB3_MODE(HDB3_MODE), .BIPOLAR_VIOLATION(bv),
		.CODE_VIOLATION(cv), .FRAME_ERROR(ev[0]), .CRC4_ERROR(ev[1]),
		.FAR_BLOCK_ERROR(ev[2]), .ALIGNMENT_CHANGE(ev[3]), .SYNC_LOSS(ev[4]),
		.PATTERN_ERROR(ev[5]), .TERMINAL_FAR_BLOCK_ERROR(ev[6]),
		.TERMINAL_CRC_ERROR(ev[7]), .IRQ(IRQ)
	);

	// ------------------------------------------------------------
	// reference counters, saturating, index order = flag bit order
	// ------------------------------------------------------------
	always @(posedge CLK_SYS) begin
		if (RST) begin
			cnt = '{default: 0};
			ovf = '0;
		end else if (CE) begin
			// the update edge opens the new period before its own events count
			if (snap_req) begin
				snap = cnt;
				cnt = '{default: 0};
				snap_req = 1'b0;
			end
			for (int k = 0; k < 9; k++) begin
				if (k < 8 ? ev[k] : (HDB3_MODE ? cv : bv)) begin
					if (cnt[k] == (1 << wid[k]) - 1) ovf[k] = 1'b1;
					else cnt[k]++;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic conclude();
		if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: read %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic chk_irq(input logic exp);
		cmp_count++;
		if (IRQ !== exp) begin
			err_total++;
			$display("ERROR %0t: interrupt %b expected %b", $time, IRQ, exp);
		end
	endtask

	// one transfer plus an idle cycle, so the next call never re-drives psel in one step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 20) begin
			err_total++;
			$display("ERROR %0t: no bus answer", $time);
			conclude();
		end
		@(posedge CLK_SYS);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {2'b00, idx, 2'b00}, {24'h000000, d});
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, {2'b00, idx, 2'b00}, 32'h00000000);
		chk(rd, {24'h000000, exp});
		chk({31'h0, er}, 32'h00000000);
	endtask

	task automatic burst(input int cycles);
		repeat (cycles) begin
			ev <= 9'($urandom);
			bv <= 1'($urandom);
			cv <= 1'($urandom);
			CE <= ($urandom % 8) != 0;
			@(posedge CLK_SYS);
		end
		ev <= '0;
		bv <= 1'b0;
		cv <= 1'b0;
		CE <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
	endtask

	// the model updates at the next edge, which also carries the events e
	task automatic model_snap(input logic [8:0] e);
		snap_req <= 1'b1;
		ev <= e;
		bv <= e[8];
		cv <= e[8];
		@(posedge CLK_SYS);
		ev <= '0;
		bv <= 1'b0;
		cv <= 1'b0;
	endtask

	function automatic logic [7:0] exp_ind(input int i);
		int kof[16] = '{1, 1, 0, 0, 3, 4, 5, 5, 8, 8, 7, 7, 2, 2, 6, 6};
		int v;
		v = snap[kof[i]];
		return (i[0] && i != 5) ? 8'(v >> 8) : 8'(v);
	endfunction

	task automatic check_bank();
		for (int i = 0; i < 16; i++) begin
			wr(REG_INDIRECT_SELECT, 8'(i));
			rdc(REG_INDIRECT_SELECT, 8'(i));
			rdc(REG_INDIRECT_DATA, exp_ind(i));
		end
	endtask

	task automatic check_flags();
		rdc(REG_OVF_FLAGS_0, ovf[7:0]);
		rdc(REG_OVF_FLAGS_1, {7'h00, ovf[8]});
		chk_irq(|(ovf & en));
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		static logic [7:0] regs[6] = '{REG_INDIRECT_SELECT, REG_UPDATE_CTRL, REG_OVF_ENABLE_0,
			REG_OVF_ENABLE_1, REG_OVF_FLAGS_0, REG_OVF_FLAGS_1};
		en = '0;
		void'($urandom(32'hC175));
		repeat (5) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		foreach (regs[i]) rdc(regs[i], 8'h00);
		apb(1'b0, 12'h040, 32'h00000000);
		chk({31'h0, er}, 32'h00000001);
		apb(1'b0, 12'h039, 32'h00000000);
		chk({31'h0, er}, 32'h00000001);
		apb(1'b0, 12'h438, 32'h00000000);
		chk({31'h0, er}, 32'h00000001);
		chk(rd, 32'h00000000);
		wr(REG_INDIRECT_DATA, 8'hA5);
		PSTRB <= 4'h0;
		wr(REG_OVF_ENABLE_0, 8'hFF);
		PSTRB <= 4'hF;
		rdc(REG_OVF_ENABLE_0, 8'h00);
		for (int r = 0; r < 2; r++) begin
			HDB3_MODE <= r[0];
			burst(50 + r * 70);
			// write lands at the third edge, the update edge follows with events on it
			fork
				wr(REG_UPDATE_CTRL, 8'h01);
				begin
					repeat (3) @(posedge CLK_SYS);
					model_snap(9'h1FF);
				end
			join
			wr(REG_UPDATE_CTRL, 8'h00);
			check_bank();
			en = r ? 9'h1F0 : 9'h00F;
			wr(REG_OVF_ENABLE_0, en[7:0]);
			wr(REG_OVF_ENABLE_1, {7'h00, en[8]});
			rdc(REG_OVF_ENABLE_1, {7'h00, en[8]});
			check_flags();
			wr(REG_OVF_FLAGS_0, 8'hFF);
			wr(REG_OVF_FLAGS_1, 8'h01);
			ovf = '0;
			check_flags();
		end
		// only one tick may fall before auto is switched off again
		burst(30);
		wr(REG_UPDATE_CTRL, 8'h02);
		rdc(REG_UPDATE_CTRL, 8'h02);
		repeat (TICKS + 5) @(posedge CLK_SYS);
		wr(REG_UPDATE_CTRL, 8'h00);
		model_snap(9'h000);
		check_bank();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge CLK_SYS);
		err_total++;
		$display("ERROR %0t: run limit reached", $time);
		conclude();
	end
endmodule

bind e1_performance_monitor perfmon_props props_u (
	.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .IRQ(IRQ)
);
